// file: verilog/fault_watchdog_pkg.sv
// Constants, register layout and types for the fault watchdog.
// Assumes a 100 MHz hclk that also serves as the machine cycle clock.
`default_nettype none

package fault_watchdog_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register map (index printed, byte address is four times it)
   localparam logic [7:0] CTRL_INDEX = 8'h2e;
   localparam int ADDR_W = 10;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
   localparam logic [7:0] CTRL_RESET = 8'h7f;
   localparam int ACTIVE_BIT = 7;
   localparam int TOP_BIT = 6;
   localparam logic [6:0] CNT_EXPIRE = 7'h40;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int STEP_CYCLES = 16000;
   localparam int RST_PULSE_NS = 30000;
   localparam int RST_PULSE_CYCLES = (RST_PULSE_NS * CLK_MHZ) / 1000;
   localparam int PHASE_SHORT_CYCLES = 256;
   localparam int PHASE_LONG_CYCLES = 4096;
   localparam int TMR_W = 13;

   ////////////////////////////////////////////////////////////////////////
   // Bus and state types
   typedef struct packed {
      logic valid;
      logic write;
      logic hit;
   } ahb_req_t;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_PULSE,
      ST_PHASE
   } wd_state_t;

endpackage : fault_watchdog_pkg

`default_nettype wire

// file: verilog/fault_watchdog.sv
// AHB-Lite fault watchdog: free-running 7-bit countdown with chip reset.
// Assumes one AHB-Lite master, halt and option levels on the hclk domain.
`default_nettype none

// Overview of operation
// [R1] Count steps down once per 16000 machine cycles, 64 programmable steps.
// [R2] Active watchdog passing 40h to 3Fh starts an about 30 us reset pulse.
// [R3] Countdown keeps running even while the watchdog is inactive.
// [R4] Software refreshes periodically with C0h to FFh.
// [R5] Low six counter bits give steps from refresh to reset.
// [R6] Inactive after reset; activation bit set-only, cleared by reset alone.
// [R7] Reset generated only while activation bit is one.
// [R8] Write setting active and clearing top bit forces immediate reset.
// [R9] Halt while active resets unless no-reset-on-halt option is set.
// [R10] Hardware option makes watchdog always active, activation bit unused.
// [R11] Control register resets to 7Fh.
// [R12] Bit 7 activation, bits 6:0 count; reading returns current count.
// [R13] C0h times out in 1 to 2 ms, FFh in 127 to 128 ms; at 100 MHz the code gives 0 to 0.16 ms and 10.08 to 10.24 ms.
// [R14] Reset phase of 256 or 4096 cycles follows the timeout.
// [R15] With no-reset-on-halt, software refreshes before halt.
module fault_watchdog
   import fault_watchdog_pkg::*;
#(
   parameter int STEP_CYCLES_P = STEP_CYCLES,
   parameter int PRE_W = 14
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic halt_exec,
   input wire logic hw_watchdog_opt,
   input wire logic no_reset_on_halt_option,
   input wire logic long_reset_phase_opt,
   output logic chip_reset_n,
   output logic reset_phase_busy
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   ahb_req_t req_ff, nxt_req;
   logic [31:0] hrdata_ff, nxt_hrdata;
   logic hreadyout_ff, hresp_ff;
   logic [PRE_W-1:0] pre_ff, nxt_pre;
   logic [6:0] count_ff, nxt_count;
   logic active_ff, nxt_active;
   wd_state_t state_ff, nxt_state;
   logic [TMR_W-1:0] tmr_ff, nxt_tmr;
   logic chip_reset_n_ff, nxt_chip_reset_n;
   logic busy_ff, nxt_busy;
   logic wr_en, step, active_eff, expire, force_rst, halt_rst, trigger;
   logic pulse_done, phase_done;
   logic [TMR_W-1:0] phase_last;
   logic unused_ok;

   function automatic logic addr_hit(input logic [31:0] a);
      addr_hit = (a[ADDR_W-1:0] == CTRL_ADDR) && (a[31:ADDR_W] == '0);
   endfunction : addr_hit

   assign unused_ok = ^{hsize, hwdata[31:8]};

   ////////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait states, reads sampled in the address phase
   always_comb begin
      nxt_req = req_ff;
      nxt_hrdata = 32'h0000_0000;
      if (hready) begin
         nxt_req.valid = hsel && htrans[1];
         nxt_req.write = hwrite;
         nxt_req.hit = addr_hit(haddr);
         if (hsel && htrans[1] && !hwrite && addr_hit(haddr)) begin
            nxt_hrdata = {24'h0000_00, active_ff, count_ff}; // [R12]
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_ff <= '0;
         hrdata_ff <= 32'h0000_0000;
         hreadyout_ff <= 1'b0;
         hresp_ff <= 1'b0;
      end else begin
         req_ff <= nxt_req;
         hrdata_ff <= nxt_hrdata;
         hreadyout_ff <= 1'b1; // Never stretches a transfer
         hresp_ff <= 1'b0;
      end
   end

   assign wr_en = req_ff.valid && req_ff.write && req_ff.hit;

   ////////////////////////////////////////////////////////////////////////
   // Prescaler: never cleared by a write, hence the one-step spread
   always_comb begin
      step = (pre_ff == PRE_W'(STEP_CYCLES_P - 1)); // [R1] [R13]
      nxt_pre = step ? '0 : pre_ff + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register and reset triggers
   always_comb begin
      active_eff = active_ff || hw_watchdog_opt; // [R10]
      expire = step && !wr_en && (count_ff == CNT_EXPIRE) && active_eff; // [R2] [R7]
      force_rst = wr_en && !hwdata[TOP_BIT] && (hwdata[ACTIVE_BIT] || active_eff); // [R8]
      halt_rst = halt_exec && active_eff && !no_reset_on_halt_option; // [R9]
      trigger = (state_ff == ST_RUN) && (expire || force_rst || halt_rst);
      nxt_count = count_ff;
      nxt_active = active_ff;
      if (wr_en) begin
         nxt_count = hwdata[6:0]; // [R5]
         nxt_active = active_ff || hwdata[ACTIVE_BIT]; // [R6]
      end else if (step) begin
         nxt_count = count_ff - 7'd1; // [R1] [R3]
      end
      if (phase_done) begin
         nxt_count = CTRL_RESET[6:0]; // [R6] [R11]
         nxt_active = CTRL_RESET[ACTIVE_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_ff <= '0;
         count_ff <= CTRL_RESET[6:0]; // [R11]
         active_ff <= CTRL_RESET[ACTIVE_BIT];
      end else begin
         pre_ff <= nxt_pre;
         count_ff <= nxt_count;
         active_ff <= nxt_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset sequencer: pin pulse, then the reset phase
   always_comb begin
      phase_last = long_reset_phase_opt ? TMR_W'(PHASE_LONG_CYCLES - 1)
                                        : TMR_W'(PHASE_SHORT_CYCLES - 1); // [R14]
      pulse_done = (state_ff == ST_PULSE) && (tmr_ff == TMR_W'(RST_PULSE_CYCLES - 1));
      phase_done = (state_ff == ST_PHASE) && (tmr_ff == phase_last);
      nxt_state = state_ff;
      nxt_tmr = tmr_ff + 1'b1;
      case (state_ff)
         ST_RUN: begin
            nxt_tmr = '0;
            if (trigger) begin
               nxt_state = ST_PULSE; // [R2]
            end
         end
         ST_PULSE: begin
            if (pulse_done) begin
               nxt_state = ST_PHASE;
               nxt_tmr = '0;
            end
         end
         ST_PHASE: begin
            if (phase_done) begin
               nxt_state = ST_RUN; // [R14]
               nxt_tmr = '0;
            end
         end
         default: begin
            nxt_state = ST_RUN;
            nxt_tmr = '0;
         end
      endcase
      nxt_chip_reset_n = (nxt_state != ST_PULSE);
      nxt_busy = (nxt_state != ST_RUN);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= ST_RUN;
         tmr_ff <= '0;
         chip_reset_n_ff <= 1'b1;
         busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         tmr_ff <= nxt_tmr;
         chip_reset_n_ff <= nxt_chip_reset_n;
         busy_ff <= nxt_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = hresp_ff;
   assign chip_reset_n = chip_reset_n_ff;
   assign reset_phase_busy = busy_ff;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_step_dec;
      @(posedge hclk) disable iff (!hresetn)
      (step && !wr_en && !phase_done) |=> (count_ff == 7'($past(count_ff) - 7'd1));
   endproperty
   a_step_dec: assert property (p_step_dec) else $error("count missed a step"); // [R1]

   property p_expire_pulse;
      @(posedge hclk) disable iff (!hresetn)
      (state_ff == ST_RUN && active_eff && step && !wr_en && count_ff == 7'h40)
         |=> !chip_reset_n_ff [*8];
   endproperty
   a_expire_pulse: assert property (p_expire_pulse) else $error("no pulse on expiry"); // [R2]

   property p_free_run;
      @(posedge hclk) disable iff (!hresetn)
      (!active_eff && step && !wr_en && !phase_done) |=> $changed(count_ff);
   endproperty
   a_free_run: assert property (p_free_run) else $error("counter stalled when idle"); // [R3]

   property p_refresh_load;
      @(posedge hclk) disable iff (!hresetn)
      (wr_en && !phase_done) |=> (count_ff == $past(hwdata[6:0]));
   endproperty
   a_refresh_load: assert property (p_refresh_load) else $error("refresh not loaded"); // [R5]

   property p_active_sticky;
      @(posedge hclk) disable iff (!hresetn)
      (active_ff && !phase_done) |=> active_ff;
   endproperty
   a_active_sticky: assert property (p_active_sticky) else $error("active bit cleared"); // [R6]

   property p_no_reset_inactive;
      @(posedge hclk) disable iff (!hresetn)
      (state_ff == ST_RUN && !active_eff && !(wr_en && hwdata[ACTIVE_BIT]))
         |=> chip_reset_n_ff;
   endproperty
   a_no_reset_inactive: assert property (p_no_reset_inactive) else $error("reset while off"); // [R7]

   property p_force;
      @(posedge hclk) disable iff (!hresetn)
      (state_ff == ST_RUN && wr_en && hwdata[ACTIVE_BIT] && !hwdata[TOP_BIT])
         |=> !chip_reset_n_ff;
   endproperty
   a_force: assert property (p_force) else $error("forced reset missing"); // [R8]

   property p_halt;
      @(posedge hclk) disable iff (!hresetn)
      (state_ff == ST_RUN && halt_exec && active_eff && !no_reset_on_halt_option)
         |=> !chip_reset_n_ff;
   endproperty
   a_halt: assert property (p_halt) else $error("halt did not reset"); // [R9]

   property p_hw_opt;
      @(posedge hclk) disable iff (!hresetn)
      (state_ff == ST_RUN && hw_watchdog_opt && step && !wr_en && count_ff == 7'h40)
         |=> !chip_reset_n_ff;
   endproperty
   a_hw_opt: assert property (p_hw_opt) else $error("hardware option ignored"); // [R10]

   property p_self_clear;
      @(posedge hclk) disable iff (!hresetn)
      phase_done |=> ({active_ff, count_ff} == 8'h7f) && chip_reset_n_ff && !busy_ff;
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("not back to 7Fh"); // [R11] [R14]

   property p_read;
      @(posedge hclk) disable iff (!hresetn)
      (hready && hsel && htrans[1] && !hwrite && addr_hit(haddr))
         |=> (hrdata_ff[7:0] == $past({active_ff, count_ff})) && (hrdata_ff[31:8] == '0);
   endproperty
   a_read: assert property (p_read) else $error("read value wrong"); // [R12]

   property p_pre_wrap;
      @(posedge hclk) disable iff (!hresetn)
      step |=> (pre_ff == '0);
   endproperty
   a_pre_wrap: assert property (p_pre_wrap) else $error("prescaler did not wrap"); // [R1]

   property p_halt_quiet;
      @(posedge hclk) disable iff (!hresetn)
      (state_ff == ST_RUN && halt_exec && no_reset_on_halt_option && !wr_en
         && !(step && count_ff == CNT_EXPIRE)) |=> chip_reset_n_ff;
   endproperty
   a_halt_quiet: assert property (p_halt_quiet) else $error("halt not suppressed"); // [R9]

   property p_low_busy;
      @(posedge hclk) disable iff (!hresetn)
      !chip_reset_n_ff |-> busy_ff;
   endproperty
   a_low_busy: assert property (p_low_busy) else $error("pulse outside busy"); // [R14]

   c_expire: cover property (@(posedge hclk) disable iff (!hresetn)
      (state_ff == ST_RUN) && expire);
   c_force: cover property (@(posedge hclk) disable iff (!hresetn)
      (state_ff == ST_RUN) && force_rst);
   c_halt: cover property (@(posedge hclk) disable iff (!hresetn)
      (state_ff == ST_RUN) && halt_rst);
   c_phase_end: cover property (@(posedge hclk) disable iff (!hresetn) phase_done);
   c_hw_expire: cover property (@(posedge hclk) disable iff (!hresetn)
      hw_watchdog_opt && !active_ff && expire);

endmodule : fault_watchdog

`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the fault watchdog: bus reads and writes, timeouts.
// Assumes a short prescaler (16 cycles a step) and zero-wait AHB-Lite slave.
`default_nettype none

`define CHK(a, e) begin comparisons++; if (32'(a) !== 32'(e)) begin n_mismatch++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, 32'(a), 32'(e)); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fault_watchdog_pkg::*;

   localparam int STEP = 16;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic halt_exec = 1'b0;
   logic hw_opt = 1'b0;
   logic nohalt_opt = 1'b0;
   logic long_opt = 1'b0;
   wire logic hready;
   wire logic [31:0] hrdata;
   wire logic hresp;
   wire logic chip_reset_n;
   wire logic reset_phase_busy;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   int n;
   logic [31:0] rd;
   logic [31:0] rd2;
   logic [7:0] codes [3] = '{8'hc0, 8'hc2, 8'hff};
   localparam logic [31:0] CTRL = {22'h0, CTRL_ADDR};

   fault_watchdog #(.STEP_CYCLES_P(STEP), .PRE_W(14)) fault_watchdog_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .halt_exec(halt_exec),
      .hw_watchdog_opt(hw_opt), .no_reset_on_halt_option(nohalt_opt),
      .long_reset_phase_opt(long_opt), .chip_reset_n(chip_reset_n),
      .reset_phase_busy(reset_phase_busy));

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the run needs about 30000 cycles
   always #5 hclk = ~hclk;

   always @(posedge hclk) begin
      cycles++;
      if (cycles > 60000) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////
   // One single-word transfer; address phase held until hready seen high
   task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                           output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      `CHK(hresp, 1'b0)
      hwrite <= 1'b0;
   endtask : ahb_xfer

   // Cycles until the chip reset goes low, saturating at lim
   task automatic wait_low(input int lim, output int cnt);
      cnt = 0;
      @(negedge hclk);
      while (chip_reset_n !== 1'b0 && cnt < lim) begin
         @(negedge hclk);
         cnt++;
      end
   endtask : wait_low

   // Measures pulse and reset phase, then expects the register back at 7Fh
   task automatic pulse_check(input int phase);
      int lo;
      int bz;
      lo = 0;
      bz = 0;
      while (chip_reset_n === 1'b0 && lo < 5000) begin
         @(negedge hclk);
         lo++;
      end
      while (reset_phase_busy === 1'b1 && bz < 5000) begin
         @(negedge hclk);
         bz++;
      end
      `CHK(lo, RST_PULSE_CYCLES)
      `CHK(bz, phase)
      ahb_xfer(1'b0, CTRL, 32'h0, rd);
      `CHK(rd, 32'h0000_007f)
   endtask : pulse_check

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      ahb_xfer(1'b0, CTRL, 32'h0, rd);
      `CHK(rd, CTRL_RESET)
      // Free count while inactive, ten steps between reads
      ahb_xfer(1'b0, CTRL, 32'h0, rd);
      repeat (10 * STEP - 2) @(posedge hclk);
      ahb_xfer(1'b0, CTRL, 32'h0, rd2);
      `CHK(7'(rd[6:0] - rd2[6:0]), 7'd10)
      // Crossing 40h while inactive must stay quiet
      wait_low(70 * STEP, n);
      `CHK(n, 70 * STEP)
      // Unmapped place reads zero and swallows writes
      ahb_xfer(1'b1, CTRL + 32'h4, 32'h0000_0080, rd);
      ahb_xfer(1'b0, CTRL + 32'h4, 32'h0, rd);
      `CHK(rd, 32'h0)
      ahb_xfer(1'b0, CTRL, 32'h0, rd);
      `CHK(rd[7], 1'b0)
      // Refresh codes: delay follows the low six bits
      foreach (codes[i]) begin
         ahb_xfer(1'b1, CTRL, {24'h0, codes[i]}, rd);
         ahb_xfer(1'b0, CTRL, 32'h0, rd);
         `CHK(rd[7], 1'b1)
         wait_low(70 * STEP, n);
         `CHK(n >= int'(codes[i][5:0]) * STEP - 2, 1'b1)
         `CHK(n <= (int'(codes[i][5:0]) + 1) * STEP + 2, 1'b1)
         pulse_check(PHASE_SHORT_CYCLES);
      end
      // Forced reset with the long phase
      @(posedge hclk);
      long_opt <= 1'b1;
      ahb_xfer(1'b1, CTRL, 32'h0000_0080, rd);
      wait_low(8, n);
      `CHK(n <= 3, 1'b1)
      pulse_check(PHASE_LONG_CYCLES);
      @(posedge hclk);
      long_opt <= 1'b0;
      hw_opt <= 1'b1;
      // Hardware option: active without the bit
      wait_low(70 * STEP, n);
      `CHK(n < 70 * STEP, 1'b1)
      pulse_check(PHASE_SHORT_CYCLES);
      @(posedge hclk);
      hw_opt <= 1'b0;
      // Halt while active, first suppressed, then resetting
      ahb_xfer(1'b1, CTRL, 32'h0000_00ff, rd);
      // Software cannot clear the activation bit once set
      ahb_xfer(1'b1, CTRL, 32'h0000_007f, rd);
      ahb_xfer(1'b0, CTRL, 32'h0, rd);
      `CHK(rd, 32'h0000_00ff)
      @(posedge hclk);
      nohalt_opt <= 1'b1;
      halt_exec <= 1'b1;
      wait_low(50, n);
      `CHK(n, 50)
      @(posedge hclk);
      nohalt_opt <= 1'b0;
      wait_low(4, n);
      `CHK(n <= 2, 1'b1)
      @(posedge hclk);
      halt_exec <= 1'b0;
      pulse_check(PHASE_SHORT_CYCLES);
      // Mid-run bus reset returns an armed watchdog to 7Fh
      ahb_xfer(1'b1, CTRL, 32'h0000_00ff, rd);
      @(posedge hclk);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      ahb_xfer(1'b0, CTRL, 32'h0, rd);
      `CHK(rd, CTRL_RESET)
      `CHK(chip_reset_n, 1'b1)
      finish_test();
   end
endmodule : tb

`undef CHK
`default_nettype wire
